// File: core/psac_pkg.sv
// Constants, register map and types for the pump staging controller
package psac_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int DEAD_NS = 20_000;
    localparam int DEAD_CYCLES = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NDRV = 4;
    localparam int NSTG = 3;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_INTERVAL = 8'h04;
    localparam logic [7:0] OFS_ROT_FLIM = 8'h08;
    localparam logic [7:0] OFS_FMAX = 8'h0C;
    localparam logic [7:0] OFS_STAGE0 = 8'h10;
    localparam logic [7:0] OFS_STAGE1 = 8'h14;
    localparam logic [7:0] OFS_STAGE2 = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_TIMER = 8'h20;
    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int CTRL_ROT_EN = 0;
    localparam int CTRL_SCOPE = 1;
    localparam int CTRL_POLICY_LO = 2;
    localparam int CTRL_MAXAUX_LO = 4;
    // ************************************************************
    // Policy codes and reset values
    // ************************************************************
    localparam logic [1:0] POLICY_UNUSED = 2'h0;
    localparam logic [1:0] POLICY_APPEND = 2'h1;
    localparam logic [1:0] POLICY_RESTART = 2'h2;
    localparam logic [2:0] MAXAUX_RST = 3'h3;
    localparam logic [31:0] INTERVAL_RST = 32'h0000_0000;
    localparam logic [15:0] ROT_FLIM_RST = 16'h0000;
    localparam logic [15:0] FMAX_RST = 16'h1388;
    localparam logic [15:0] START_F_RST = 16'h1388;
    localparam logic [15:0] STOP_F_RST = 16'h0000;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        ST_REST = 4'b0001,
        ST_DEAD = 4'b0010,
        ST_START = 4'b0100,
        ST_RUN = 4'b1000
    } psac_state_t;
    typedef logic [NDRV-1:0][1:0] psac_order_t;
endpackage

// File: core/psac_core.sv
// Pump staging and start-order rotation controller with AHB-Lite registers
// How it works
// - Rotation runs only when the rotation enable bit is one.
// - Scope zero rotates auxiliaries only; scope one includes the main drive.
// - Rotate when interval expired and capacity in use is below limit.
// - Rotation stops all running drives, then restarts in new order.
// - The main drive relay is energised first, auxiliaries after it.
// - A rotation blocked by capacity waits until capacity falls.
// - Interval timer counts only while start request A is active.
// - Timer clears after each rotation and when start request A drops.
// - Rotation allowed while fewer auxiliaries run than the maximum.
// - At maximum count, rotation needs frequency below rotation limit.
// - Zero rotation limit allows rotation only at rest.
// - Unless policy is zero, only drives with active interlock run; works without rotation.
// - Lost auxiliary interlock starts a spare without stopping main drive.
// - Lost main drive interlock stops all and restarts with new set-up.
// - Policy zero ignores interlocks; one appends re-enabled drive last.
// - Policy two stops all on re-enable and restarts with new set-up.
// - Unless policy is zero, each drive's relay is enabled only by its own interlock input.
// - Next auxiliary starts when frequency reaches its start frequency.
// - After a start the main drive is held at or above stop frequency.
// - With no auxiliary left the main drive may rise to maximum.
// - Auxiliaries stop in reverse of the current start order.
module psac_core #(
    parameter int unsigned TICK_CYCLES = psac_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic start_a,
    input wire logic sleep_in,
    input wire logic [3:0] interlock_in,
    input wire logic [15:0] freq_in,
    output logic [3:0] relay_vfd,
    output logic [3:0] relay_mains,
    output logic [15:0] freq_ceiling,
    output logic [15:0] freq_floor
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        psac_pkg::psac_state_t state;
        logic rot_en;
        logic scope;
        logic [1:0] policy;
        logic [2:0] max_aux;
        logic [31:0] interval;
        logic [15:0] flim;
        logic [15:0] fmax;
        logic [2:0][15:0] start_f;
        logic [2:0][15:0] stop_f;
        psac_pkg::psac_order_t order;
        logic [1:0] base;
        logic [3:0] aux_on;
        logic force_spare;
        logic [2:0] restore;
        logic [31:0] tick;
        logic [31:0] ms;
        logic [15:0] dead;
        logic [3:0] il_prev;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [3:0] vfd;
        logic [3:0] mains;
        logic [15:0] ceil;
        logic [15:0] floor;
    } psac_regs_t;

    psac_regs_t s_r;
    psac_regs_t s_nxt;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic psac_pkg::psac_order_t gen_order(
        input logic [1:0] base,
        input logic scope
    );
        psac_pkg::psac_order_t o;
        for (int k = 0; k < psac_pkg::NDRV; k++) begin
            if (scope) begin
                o[k] = 2'(int'(base) + k);
            end else if (k == 0) begin
                o[k] = 2'h0;
            end else begin
                o[k] = 2'(1 + ((int'(base) + k - 1) % 3));
            end
        end
        return o;
    endfunction

    function automatic logic [2:0] popcnt(input logic [3:0] v);
        logic [2:0] c;
        c = 3'h0;
        for (int k = 0; k < 4; k++) begin
            c = c + {2'h0, v[k]};
        end
        return c;
    endfunction

    // First usable drive of the order that is neither on nor the main one
    function automatic logic [2:0] pick_next(
        input psac_pkg::psac_order_t o,
        input logic [3:0] usable,
        input logic [3:0] on,
        input logic [3:0] conv
    );
        logic [2:0] r;
        logic [1:0] d;
        r = 3'h0;
        for (int k = psac_pkg::NDRV - 1; k >= 0; k--) begin
            d = o[k];
            if (usable[d] && !on[d] && !conv[d]) begin
                r = {1'b1, d};
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] pick_last(
        input psac_pkg::psac_order_t o,
        input logic [3:0] on
    );
        logic [1:0] r;
        r = 2'h0;
        for (int k = 0; k < psac_pkg::NDRV; k++) begin
            if (on[o[k]]) begin
                r = o[k];
            end
        end
        return r;
    endfunction

    // One-hot mask of the drive on the converter, empty when none
    function automatic logic [3:0] pick_conv(
        input psac_pkg::psac_order_t o,
        input logic [3:0] usable,
        input logic scope
    );
        logic [3:0] m;
        m = 4'h0;
        if (!scope) begin
            m[0] = usable[0];
        end else begin
            for (int k = psac_pkg::NDRV - 1; k >= 0; k--) begin
                if (usable[o[k]]) begin
                    m = 4'h0;
                    m[o[k]] = 1'b1;
                end
            end
        end
        return m;
    endfunction

    function automatic psac_pkg::psac_order_t append(
        input psac_pkg::psac_order_t o,
        input logic [1:0] d
    );
        psac_pkg::psac_order_t r;
        int j;
        r = o;
        j = 0;
        for (int k = 0; k < psac_pkg::NDRV; k++) begin
            if (o[k] != d) begin
                r[j] = o[k];
                j = j + 1;
            end
        end
        r[psac_pkg::NDRV-1] = d;
        return r;
    endfunction

    function automatic logic [1:0] first_set(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int k = 3; k >= 0; k--) begin
            if (v[k]) begin
                r = 2'(k);
            end
        end
        return r;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [3:0] usable;
        logic [3:0] usable_p;
        logic [3:0] conv;
        logic [3:0] conv_p;
        logic [3:0] lost;
        logic [3:0] gained;
        logic [3:0] live;
        logic [2:0] nrun;
        logic [2:0] nxt_pick;
        logic rest;
        logic expired;
        logic allow;
        logic rotate;
        logic want;
        logic [1:0] base_inc;
        logic [7:0] ra;
        usable = 4'h0;
        usable_p = 4'h0;
        conv = 4'h0;
        conv_p = 4'h0;
        lost = 4'h0;
        gained = 4'h0;
        live = 4'h0;
        nrun = 3'h0;
        nxt_pick = 3'h0;
        rest = 1'b0;
        expired = 1'b0;
        allow = 1'b0;
        rotate = 1'b0;
        want = 1'b0;
        base_inc = 2'h0;
        ra = 8'h00;
        s_nxt = s_r;

        // Interlock view
        usable = (s_r.policy == psac_pkg::POLICY_UNUSED) ?
            4'hF : interlock_in;
        usable_p = (s_r.policy == psac_pkg::POLICY_UNUSED) ?
            4'hF : s_r.il_prev;
        lost = usable_p & ~usable;
        gained = ~usable_p & usable;
        s_nxt.il_prev = interlock_in;
        conv = pick_conv(s_r.order, usable, s_r.scope);
        conv_p = pick_conv(s_r.order, usable_p, s_r.scope);
        live = s_r.aux_on & usable & ~conv;
        nrun = popcnt(live);
        s_nxt.aux_on = live;

        // Rotation timer
        if (!start_a) begin
            s_nxt.tick = 32'h0000_0000;
            s_nxt.ms = 32'h0000_0000;
        end else if (s_r.tick >= TICK_CYCLES - 1) begin
            s_nxt.tick = 32'h0000_0000;
            if (s_r.ms < s_r.interval) begin
                s_nxt.ms = s_r.ms + 32'h0000_0001;
            end
        end else begin
            s_nxt.tick = s_r.tick + 32'h0000_0001;
        end
        rest = !start_a || sleep_in;
        expired = s_r.interval != 32'h0000_0000 && s_r.ms >= s_r.interval;
        if (s_r.flim == 16'h0000) begin
            allow = rest;
        end else begin
            allow = nrun < s_r.max_aux ||
                (nrun == s_r.max_aux && freq_in < s_r.flim);
        end
        rotate = s_r.rot_en && expired && allow;
        if (s_r.scope) begin
            base_inc = s_r.base + 2'h1;
        end else begin
            base_inc = (s_r.base >= 2'h2) ? 2'h0 : s_r.base + 2'h1;
        end

        // Sequencer
        unique case (s_r.state)
            psac_pkg::ST_REST: begin
                s_nxt.aux_on = 4'h0;
                s_nxt.restore = 3'h0;
                s_nxt.force_spare = 1'b0;
                s_nxt.order = gen_order(s_r.base, s_r.scope);
                if (rotate) begin
                    s_nxt.base = base_inc;
                    s_nxt.order = gen_order(base_inc, s_r.scope);
                    s_nxt.ms = 32'h0000_0000;
                    s_nxt.tick = 32'h0000_0000;
                end else if (!rest) begin
                    s_nxt.state = psac_pkg::ST_START;
                end
            end
            psac_pkg::ST_DEAD: begin
                s_nxt.aux_on = 4'h0;
                s_nxt.force_spare = 1'b0;
                s_nxt.order = gen_order(s_r.base, s_r.scope);
                if (s_r.dead >= 16'(psac_pkg::DEAD_CYCLES - 1)) begin
                    s_nxt.dead = 16'h0000;
                    s_nxt.state = psac_pkg::ST_START;
                end else begin
                    s_nxt.dead = s_r.dead + 16'h0001;
                end
            end
            psac_pkg::ST_START: begin
                s_nxt.state = psac_pkg::ST_RUN;
            end
            psac_pkg::ST_RUN: begin
                nxt_pick = pick_next(s_r.order, usable, live, conv);
                want = s_r.force_spare || s_r.restore > nrun;
                if (s_r.restore <= nrun) begin
                    s_nxt.restore = 3'h0;
                end
                if (rest) begin
                    s_nxt.state = psac_pkg::ST_REST;
                    s_nxt.aux_on = 4'h0;
                end else if (rotate) begin
                    s_nxt.base = base_inc;
                    s_nxt.ms = 32'h0000_0000;
                    s_nxt.tick = 32'h0000_0000;
                    s_nxt.restore = nrun;
                    s_nxt.state = psac_pkg::ST_DEAD;
                end else if ((lost & conv_p) != 4'h0) begin
                    s_nxt.restore = nrun;
                    s_nxt.state = psac_pkg::ST_DEAD;
                end else if (gained != 4'h0 &&
                    s_r.policy == psac_pkg::POLICY_RESTART) begin
                    s_nxt.restore = nrun + 3'h1;
                    s_nxt.state = psac_pkg::ST_DEAD;
                end else if (gained != 4'h0) begin
                    s_nxt.order = append(s_r.order,
                        first_set(gained));
                end else if (nxt_pick[2] && nrun < s_r.max_aux &&
                    (want || freq_in >= s_r.start_f[2'(nrun)])) begin
                    s_nxt.aux_on[nxt_pick[1:0]] = 1'b1;
                    s_nxt.force_spare = 1'b0;
                end else if (!want && nrun != 3'h0 &&
                    freq_in <= s_r.stop_f[2'(nrun - 3'h1)]) begin
                    s_nxt.aux_on[pick_last(s_r.order, live)] = 1'b0;
                end else if (!nxt_pick[2]) begin
                    s_nxt.force_spare = 1'b0;
                end
            end
        endcase
        // Stop-all drops every mains contactor at once with the converter
        if (s_nxt.state == psac_pkg::ST_DEAD) begin
            s_nxt.aux_on = 4'h0;
        end
        // Set after the sequencer so a loss in a clearing cycle is kept
        if ((lost & s_r.aux_on & ~conv_p) != 4'h0) begin
            s_nxt.force_spare = 1'b1;
        end

        // Relay and frequency band outputs
        s_nxt.vfd = 4'h0;
        if (s_nxt.state == psac_pkg::ST_START ||
            s_nxt.state == psac_pkg::ST_RUN) begin
            s_nxt.vfd = conv & usable;
        end
        s_nxt.mains = s_nxt.aux_on & usable & ~conv;
        nrun = popcnt(s_nxt.mains);
        nxt_pick = pick_next(s_nxt.order, usable, s_nxt.mains, conv);
        if (nxt_pick[2] && nrun < s_r.max_aux) begin
            s_nxt.ceil = s_r.start_f[2'(nrun)];
        end else begin
            s_nxt.ceil = s_r.fmax;
        end
        if (nrun != 3'h0) begin
            s_nxt.floor = s_r.stop_f[2'(nrun - 3'h1)];
        end else begin
            s_nxt.floor = 16'h0000;
        end

        // Bus write data phase
        s_nxt.wr_pend = 1'b0;
        if (s_r.wr_pend) begin
            unique case (s_r.wr_addr)
                psac_pkg::OFS_CTRL: begin
                    s_nxt.rot_en = hwdata[psac_pkg::CTRL_ROT_EN];
                    s_nxt.scope = hwdata[psac_pkg::CTRL_SCOPE];
                    s_nxt.policy = hwdata[psac_pkg::CTRL_POLICY_LO +: 2];
                    s_nxt.max_aux = hwdata[psac_pkg::CTRL_MAXAUX_LO +: 3];
                end
                psac_pkg::OFS_INTERVAL: s_nxt.interval = hwdata;
                psac_pkg::OFS_ROT_FLIM: s_nxt.flim = hwdata[15:0];
                psac_pkg::OFS_FMAX: s_nxt.fmax = hwdata[15:0];
                psac_pkg::OFS_STAGE0: begin
                    s_nxt.start_f[0] = hwdata[15:0];
                    s_nxt.stop_f[0] = hwdata[31:16];
                end
                psac_pkg::OFS_STAGE1: begin
                    s_nxt.start_f[1] = hwdata[15:0];
                    s_nxt.stop_f[1] = hwdata[31:16];
                end
                psac_pkg::OFS_STAGE2: begin
                    s_nxt.start_f[2] = hwdata[15:0];
                    s_nxt.stop_f[2] = hwdata[31:16];
                end
                default: begin
                end
            endcase
        end

        // Bus address phase; read data is registered for the data phase
        ra = {haddr[7:2], 2'b00};
        s_nxt.rdata = 32'h0000_0000;
        if (hsel && htrans[1] && hready && haddr[31:8] == 24'h0) begin
            s_nxt.wr_pend = hwrite;
            s_nxt.wr_addr = ra;
            if (!hwrite) begin
                unique case (ra)
                    psac_pkg::OFS_CTRL: s_nxt.rdata = {25'h0, s_r.max_aux,
                        s_r.policy, s_r.scope, s_r.rot_en};
                    psac_pkg::OFS_INTERVAL: s_nxt.rdata = s_r.interval;
                    psac_pkg::OFS_ROT_FLIM: s_nxt.rdata = {16'h0, s_r.flim};
                    psac_pkg::OFS_FMAX: s_nxt.rdata = {16'h0, s_r.fmax};
                    psac_pkg::OFS_STAGE0:
                        s_nxt.rdata = {s_r.stop_f[0], s_r.start_f[0]};
                    psac_pkg::OFS_STAGE1:
                        s_nxt.rdata = {s_r.stop_f[1], s_r.start_f[1]};
                    psac_pkg::OFS_STAGE2:
                        s_nxt.rdata = {s_r.stop_f[2], s_r.start_f[2]};
                    psac_pkg::OFS_STATUS: s_nxt.rdata = {7'(s_r.order),
                        s_r.state, 1'b0, nrun, expired, interlock_in,
                        s_r.mains, s_r.vfd, s_r.aux_on};
                    psac_pkg::OFS_TIMER: s_nxt.rdata = s_r.ms;
                    default: s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.state <= psac_pkg::ST_REST;
            s_r.policy <= psac_pkg::POLICY_UNUSED;
            s_r.max_aux <= psac_pkg::MAXAUX_RST;
            s_r.interval <= psac_pkg::INTERVAL_RST;
            s_r.flim <= psac_pkg::ROT_FLIM_RST;
            s_r.fmax <= psac_pkg::FMAX_RST;
            s_r.start_f <= {3{psac_pkg::START_F_RST}};
            s_r.stop_f <= {3{psac_pkg::STOP_F_RST}};
            s_r.order <= 8'hE4;
            s_r.ceil <= psac_pkg::START_F_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign relay_vfd = s_r.vfd;
    assign relay_mains = s_r.mains;
    assign freq_ceiling = s_r.ceil;
    assign freq_floor = s_r.floor;
endmodule

// File: test/psac_contactor_model.sv
// Contactor and motor switch model at the relay outputs
module psac_contactor_model (
    input wire logic hclk,
    input wire logic [3:0] relay_vfd,
    input wire logic [3:0] relay_mains,
    input wire logic [3:0] trip,
    output logic [3:0] interlock_in,
    output logic short_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each drive reports only its own motor switch
    assign interlock_in = ~trip;
    initial short_seen = 1'b0;
    // Converter and mains on one motor at once is a short
    always @(posedge hclk) begin
        if ((relay_vfd & relay_mains) != 4'h0) short_seen <= 1'b1;
    end
endmodule

// File: test/psac_core_props.sv
// Port checks for the pump staging controller
module psac_core_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [3:0] interlock_in,
    input wire logic [3:0] relay_vfd,
    input wire logic [3:0] relay_mains
);
    logic ap_w0, ap_r0, ap_rd;
    logic [1:0] pol;
    wire take = hsel & htrans[1] & hready;
    wire ctrl = (haddr[31:2] == 30'h0000_0000);
    // Tracks the written interlock policy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_w0 <= 1'b0;
            ap_r0 <= 1'b0;
            ap_rd <= 1'b0;
            pol <= 2'h0;
        end else begin
            ap_w0 <= take & hwrite & ctrl;
            ap_r0 <= take & !hwrite & ctrl;
            ap_rd <= take & !hwrite;
            if (ap_w0) pol <= hwdata[3:2];
        end
    end
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_relay_excl: assert property (
        (relay_vfd & relay_mains) == 4'h0) else $error("relay clash");
    a_ready_high: assert property (
        hreadyout) else $error("wait state seen");
    a_resp_okay: assert property (
        !hresp) else $error("error response seen");
    a_rdata_idle: assert property (
        !ap_rd |-> hrdata == 32'h0000_0000) else $error("stale read data");
    a_ctrl_read: assert property (
        ap_r0 && !$past(ap_w0) |-> hrdata[3:2] == pol)
        else $error("policy readback wrong");
    a_lock_relay: assert property (
        pol != 2'h0 && $past(pol) != 2'h0
        |-> ((relay_vfd | relay_mains) & ~$past(interlock_in)) == 4'h0)
        else $error("relay without interlock");
    a_one_start: assert property (
        $countones(relay_mains & ~$past(relay_mains)) <= 1)
        else $error("two aux started at once");
    a_main_first: assert property (
        relay_mains != 4'h0 |-> relay_vfd != 4'h0)
        else $error("aux on without main drive");
    c_aux_on: cover property ($rose(relay_mains != 4'h0));
    c_ctrl_rd: cover property (ap_r0);
    c_stop_all: cover property ($fell(relay_vfd != 4'h0));
endmodule

bind psac_core psac_core_props u_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .interlock_in, .relay_vfd, .relay_mains
);

// File: test/psac_core_tb.sv
// Self-checking bench for the pump staging controller
module psac_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, short_seen;
    logic [31:0] hrdata;
    logic start_a = 1'b0;
    logic sleep_in = 1'b0;
    logic [3:0] trip = 4'h0;
    logic [3:0] interlock_in, relay_vfd, relay_mains;
    logic [15:0] freq_in = 16'h0000;
    logic [15:0] freq_ceiling, freq_floor;
    logic rd_pend = 1'b0;
    logic [63:0] note;
    logic [63:0] note_q[$];
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc_cnt = 0;
    always #4 hclk = ~hclk;
    psac_core #(.TICK_CYCLES(10)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .start_a, .sleep_in,
        .interlock_in, .freq_in, .relay_vfd, .relay_mains, .freq_ceiling,
        .freq_floor
    );
    psac_contactor_model partner (
        .hclk, .relay_vfd, .relay_mains, .trip, .interlock_in, .short_seen
    );
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Write sends d; read notes d as expected under mask m
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] m);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0000_0000;
        if (!w) note_q.push_back({d, m});
        rd_pend <= !w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic st(input logic [3:0] v, input logic [3:0] mm);
        bus(1'b0, 8'h1C, {20'h0_0000, mm, v, 4'h0}, 32'h0000_0FF0);
    endtask
    task automatic step(input logic [15:0] f);
        @(posedge hclk);
        freq_in <= f;
        @(posedge hclk);
        freq_in <= 16'h0258;
        cyc(4);
    endtask
    always @(posedge hclk) begin
        if (rd_pend && hreadyout === 1'b1 && note_q.size() > 0) begin
            note = note_q.pop_front();
            cmp(note[63:32] & note[31:0], hrdata & note[31:0]);
            rd_pend <= 1'b0;
        end
    end
    always @(posedge hclk) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        logic [31:0] r;
        r = $urandom(98162);
        r = $urandom();
        cyc(8);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 32'h0000_0030, 32'hFFFF_FFFF);
        bus(1'b0, 8'h04, 32'h0000_0000, 32'hFFFF_FFFF);
        bus(1'b0, 8'h08, 32'h0000_0000, 32'hFFFF_FFFF);
        bus(1'b0, 8'h0C, 32'h0000_1388, 32'hFFFF_FFFF);
        for (int k = 0; k < 3; k++)
            bus(1'b0, 8'h10 + 8'(k * 4), 32'h0000_1388, 32'hFFFF_FFFF);
        bus(1'b1, 8'h40, r, 32'h0000_0000);
        bus(1'b0, 8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
        bus(1'b1, 8'h08, r, 32'h0000_0000);
        bus(1'b0, 8'h08, {16'h0000, r[15:0]}, 32'hFFFF_FFFF);
        bus(1'b1, 8'h1C, r, 32'h0000_0000);
        st(4'h0, 4'h0);
        cmp(32'h0000_1388, {16'h0000, freq_ceiling});
        for (int k = 0; k < 3; k++)
            bus(1'b1, 8'h10 + 8'(k * 4), 32'h01F4_03E8, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_0034, 32'h0000_0000);
        start_a <= 1'b1;
        cyc(6);
        st(4'h1, 4'h0);
        cmp(32'h0000_03E8, {16'h0000, freq_ceiling});
        step(16'h03E8);
        st(4'h1, 4'h2);
        cmp(32'h0000_01F4, {16'h0000, freq_floor});
        step(16'h03E8);
        st(4'h1, 4'h6);
        trip <= 4'h2;
        cyc(4);
        st(4'h1, 4'hC);
        trip <= 4'h0;
        cyc(4);
        st(4'h1, 4'hC);
        step(16'h03E8);
        st(4'h1, 4'hE);
        cmp(32'h0000_1388, {16'h0000, freq_ceiling});
        step(16'h0100);
        st(4'h1, 4'hC);
        step(16'h0100);
        st(4'h1, 4'h4);
        bus(1'b1, 8'h00, 32'h0000_0038, 32'h0000_0000);
        trip <= 4'h8;
        cyc(4);
        trip <= 4'h0;
        cyc(4);
        st(4'h0, 4'h0);
        cyc(2600);
        bus(1'b0, 8'h1C, 32'h0004_0010, 32'h000E_00F0);
        start_a <= 1'b0;
        cyc(3);
        bus(1'b0, 8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
        cyc(30);
        bus(1'b0, 8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
        bus(1'b1, 8'h08, 32'h0000_0000, 32'h0000_0000);
        bus(1'b1, 8'h04, 32'h0000_01F4, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_0034, 32'h0000_0000);
        start_a <= 1'b1;
        cyc(5100);
        bus(1'b0, 8'h1C, 32'h0001_0010, 32'h0001_00F0);
        bus(1'b1, 8'h00, 32'h0000_0035, 32'h0000_0000);
        cyc(10);
        bus(1'b0, 8'h1C, 32'h0001_0010, 32'h0001_00F0);
        sleep_in <= 1'b1;
        cyc(2700);
        bus(1'b0, 8'h1C, 32'h0000_0000, 32'h0001_0000);
        bus(1'b1, 8'h00, 32'h0000_0036, 32'h0000_0000);
        sleep_in <= 1'b0;
        cyc(4);
        st(4'h2, 4'h0);
        cmp(32'h0000_0000, {31'h0000_0000, short_seen});
        tally_and_finish();
    end
endmodule
